// [verilog/dcf_defines.svh]
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH

`define DCF_WORD_W 9
`define DCF_ADDR_W 14
`define DCF_PTR_W 15
`define DCF_DEPTH 15'h4000
`define DCF_CLK_PERIOD_NS 10
`define DCF_FLAG_SKEW_NS 5
`define DCF_PARTIAL_SKEW_NS 10
`define DCF_FLAG_SKEW_CYC \
    ((`DCF_FLAG_SKEW_NS + `DCF_CLK_PERIOD_NS - 1) / `DCF_CLK_PERIOD_NS)
`define DCF_PARTIAL_SKEW_CYC \
    ((`DCF_PARTIAL_SKEW_NS + `DCF_CLK_PERIOD_NS - 1) / `DCF_CLK_PERIOD_NS)
`define DCF_WORD_RESET 9'h000
`define DCF_PTR_RESET 15'h0000
`define DCF_PTR_ONE 15'h0001
`define DCF_FULL_B_RESET 1'b1
`define DCF_EMPTY_B_RESET 1'b0
`define DCF_ALMOST_FULL_B_RESET 1'b1
`define DCF_ALMOST_EMPTY_B_RESET 1'b0

`endif

// [verilog/dcf_pkg.sv]
package dcf_pkg;
    typedef struct packed {
        logic full_b;
        logic empty_b;
        logic almost_full_b;
        logic almost_empty_b;
    } dcf_flags_s;

    typedef struct packed {
        logic we;
        logic [13:0] addr;
        logic [8:0] data;
    } dcf_wr_s;
endpackage

// [verilog/dcf_mem.sv]
`timescale 1ns/1ps
`include "dcf_defines.svh"
module dcf_mem (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire dcf_pkg::dcf_wr_s wr,
    input wire logic re,
    input wire logic [`DCF_ADDR_W-1:0] raddr,
    output logic [`DCF_WORD_W-1:0] rdata
);
    logic [`DCF_WORD_W-1:0] store [0:(1<<`DCF_ADDR_W)-1];
    logic [`DCF_WORD_W-1:0] rdata_reg;

    // the array has no reset; only the read register does
    always_ff @(posedge sys_clk) begin
        if (wr.we) begin
            store[wr.addr] <= wr.data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= `DCF_WORD_RESET;
        end else if (re) begin
            rdata_reg <= store[raddr];
        end
    end

    assign rdata = rdata_reg;
endmodule

// [verilog/dcf_fifo.sv]
// What this block does
// RULE_01 - full releases at a write edge once the read is older than the flag skew
// RULE_02 - empty releases at a read edge once the write is older than the flag skew
// RULE_03 - reset works with both side clocks still toggling
// RULE_04 - after reset data outputs drive low with enable low, float with it high
// RULE_05 - dual-role pin high through reset makes it a second write enable
// RULE_06 - dual-role pin low through reset makes it the offset load enable (the code loads no offsets: a low pin only blocks writes and reads)
// RULE_07 - first word is at the outputs the read cycle after empty releases
// RULE_08 - first-word latency one period plus skew, two periods when skew missed
// RULE_09 - almost-empty changes at a read edge after the partial skew window
// RULE_10 - almost-empty goes low holding the empty offset count of words
// RULE_11 - almost-full goes low holding depth minus the full offset words
// RULE_12 - almost-full threshold is depth minus the programmed offset
// RULE_13 - almost-full changes at a write edge after the partial skew window
// RULE_14 - nine-bit words stored and returned in first-in first-out order
// RULE_15 - all four flags active low, each updated on its own side's edge
`timescale 1ns/1ps
`include "dcf_defines.svh"
module dcf_fifo (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wr_tick,
    input wire logic rd_tick,
    input wire logic [`DCF_WORD_W-1:0] wr_data,
    input wire logic primary_write_enable_b,
    input wire logic dual_role_write_or_load_pin,
    input wire logic read_enable_pair_b,
    input wire logic out_enable_b,
    input wire logic [`DCF_ADDR_W-1:0] empty_offset_n,
    input wire logic [`DCF_ADDR_W-1:0] full_offset_m,
    output logic [`DCF_WORD_W-1:0] rd_data,
    output logic rd_data_oe,
    output dcf_pkg::dcf_flags_s flags,
    output logic load_mode
);
    localparam int SKEW1 = `DCF_FLAG_SKEW_CYC;
    localparam int SKEW2 = `DCF_PARTIAL_SKEW_CYC;

    logic [`DCF_PTR_W-1:0] wr_ptr_reg;
    logic [`DCF_PTR_W-1:0] wr_ptr_next;
    logic [`DCF_PTR_W-1:0] rd_ptr_reg;
    logic [`DCF_PTR_W-1:0] rd_ptr_next;
    logic full_b_reg;
    logic full_b_next;
    logic empty_b_reg;
    logic empty_b_next;
    logic almost_full_b_reg;
    logic almost_full_b_next;
    logic almost_empty_b_reg;
    logic almost_empty_b_next;
    logic strap_done_reg;
    logic strap_done_next;
    logic load_mode_reg;
    logic load_mode_next;
    logic fetch_pending_reg;
    logic fetch_pending_next;
    logic [`DCF_WORD_W-1:0] rd_data_reg;
    logic [`DCF_WORD_W-1:0] rd_data_next;
    logic rd_data_oe_reg;
    logic rd_data_oe_next;
    logic [`DCF_PTR_W-1:0] rd_seen1 [0:SKEW1];
    logic [`DCF_PTR_W-1:0] wr_seen1 [0:SKEW1];
    logic [`DCF_PTR_W-1:0] rd_seen2 [0:SKEW2];
    logic [`DCF_PTR_W-1:0] wr_seen2 [0:SKEW2];
    logic wr_ok;
    logic rd_ok;
    logic [`DCF_PTR_W-1:0] fill_w1;
    logic [`DCF_PTR_W-1:0] fill_r1;
    logic [`DCF_PTR_W-1:0] fill_w2;
    logic [`DCF_PTR_W-1:0] fill_r2;
    logic [`DCF_PTR_W-1:0] af_level;
    logic [`DCF_PTR_W-1:0] ae_level;
    dcf_pkg::dcf_wr_s mem_wr;
    logic [`DCF_WORD_W-1:0] mem_rdata;

    // pointers seen by the far side lag by the skew window, so a change
    // lands at the far side's current edge only if it is old enough
    assign rd_seen1[0] = rd_ptr_reg;
    assign wr_seen1[0] = wr_ptr_reg;
    assign rd_seen2[0] = rd_ptr_reg;
    assign wr_seen2[0] = wr_ptr_reg;

    genvar gi;
    generate
        for (gi = 1; gi <= SKEW1; gi++) begin : g_skew1
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    rd_seen1[gi] <= `DCF_PTR_RESET;
                    wr_seen1[gi] <= `DCF_PTR_RESET;
                end else begin
                    rd_seen1[gi] <= rd_seen1[gi-1]; // see RULE_01
                    wr_seen1[gi] <= wr_seen1[gi-1]; // see RULE_02
                end
            end
        end
        for (gi = 1; gi <= SKEW2; gi++) begin : g_skew2
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    rd_seen2[gi] <= `DCF_PTR_RESET;
                    wr_seen2[gi] <= `DCF_PTR_RESET;
                end else begin
                    rd_seen2[gi] <= rd_seen2[gi-1]; // see RULE_13
                    wr_seen2[gi] <= wr_seen2[gi-1]; // see RULE_09
                end
            end
        end
    endgenerate

    // pointers carry one bit beyond the address, so the wrapped
    // difference is the word count even across the top of the array
    function automatic logic [`DCF_PTR_W-1:0] ptr_fill(
        input logic [`DCF_PTR_W-1:0] head,
        input logic [`DCF_PTR_W-1:0] tail
    );
        ptr_fill = head - tail;
    endfunction

    always_comb begin
        strap_done_next = 1'b1;
        load_mode_next = load_mode_reg;
        // strap sampled on the first edge after release, not under reset
        if (!strap_done_reg) begin
            load_mode_next = !dual_role_write_or_load_pin; // see RULE_05 RULE_06
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_done_reg <= 1'b0;
            load_mode_reg <= 1'b0;
        end else begin
            strap_done_reg <= strap_done_next;
            load_mode_reg <= load_mode_next;
        end
    end

    always_comb begin
        // in either mode the pin must be high for a data write: as a second
        // enable, or as a load enable that is not loading
        wr_ok = wr_tick && strap_done_reg && !primary_write_enable_b &&
                dual_role_write_or_load_pin && full_b_reg; // see RULE_05 RULE_14
        // in load mode a low load pin blocks the read, so no data word is taken
        rd_ok = rd_tick && strap_done_reg && !read_enable_pair_b && empty_b_reg &&
                !(load_mode_reg && !dual_role_write_or_load_pin); // see RULE_06
    end

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        if (wr_ok) begin
            wr_ptr_next = wr_ptr_reg + `DCF_PTR_ONE; // see RULE_14
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            // both side ticks may keep running; nothing here depends on them
            wr_ptr_reg <= `DCF_PTR_RESET; // see RULE_03
        end else begin
            wr_ptr_reg <= wr_ptr_next;
        end
    end

    always_comb begin
        rd_ptr_next = rd_ptr_reg;
        if (rd_ok) begin
            rd_ptr_next = rd_ptr_reg + `DCF_PTR_ONE; // see RULE_14
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_ptr_reg <= `DCF_PTR_RESET; // see RULE_03
        end else begin
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    always_comb begin
        fill_w1 = ptr_fill(wr_ptr_next, rd_seen1[SKEW1]);
        fill_r1 = ptr_fill(wr_seen1[SKEW1], rd_ptr_next);
        fill_w2 = ptr_fill(wr_ptr_next, rd_seen2[SKEW2]);
        fill_r2 = ptr_fill(wr_seen2[SKEW2], rd_ptr_next);
        af_level = `DCF_DEPTH - {1'b0, full_offset_m}; // see RULE_12
        ae_level = {1'b0, empty_offset_n};
    end

    // write-side flags move only on write ticks; between ticks the writer
    // must see a steady level
    always_comb begin
        full_b_next = full_b_reg;
        almost_full_b_next = almost_full_b_reg;
        if (wr_tick) begin
            full_b_next = (fill_w1 != `DCF_DEPTH); // see RULE_01 RULE_15
            almost_full_b_next = (fill_w2 < af_level); // see RULE_11 RULE_13
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            full_b_reg <= `DCF_FULL_B_RESET; // see RULE_15
            almost_full_b_reg <= `DCF_ALMOST_FULL_B_RESET;
        end else begin
            full_b_reg <= full_b_next;
            almost_full_b_reg <= almost_full_b_next;
        end
    end

    always_comb begin
        empty_b_next = empty_b_reg;
        almost_empty_b_next = almost_empty_b_reg;
        if (rd_tick) begin
            empty_b_next = (fill_r1 != `DCF_PTR_RESET); // see RULE_02 RULE_15
            almost_empty_b_next = (fill_r2 > ae_level); // see RULE_09 RULE_10
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            empty_b_reg <= `DCF_EMPTY_B_RESET; // see RULE_15
            almost_empty_b_reg <= `DCF_ALMOST_EMPTY_B_RESET;
        end else begin
            empty_b_reg <= empty_b_next;
            almost_empty_b_reg <= almost_empty_b_next;
        end
    end

    always_comb begin
        // the word taken on a read edge stands at the outputs one cycle later;
        // back to back reads stream through the memory and output registers
        fetch_pending_next = rd_ok;
        rd_data_next = rd_data_reg;
        if (fetch_pending_reg) begin
            rd_data_next = mem_rdata; // see RULE_07 RULE_08
        end
        rd_data_oe_next = !out_enable_b; // see RULE_04
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fetch_pending_reg <= 1'b0;
            rd_data_reg <= `DCF_WORD_RESET; // see RULE_04
            rd_data_oe_reg <= 1'b0;
        end else begin
            fetch_pending_reg <= fetch_pending_next;
            rd_data_reg <= rd_data_next;
            rd_data_oe_reg <= rd_data_oe_next;
        end
    end

    always_comb begin
        mem_wr.we = wr_ok;
        mem_wr.addr = wr_ptr_reg[`DCF_ADDR_W-1:0];
        mem_wr.data = wr_data;
    end

    dcf_mem u_mem (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr(mem_wr),
        .re(rd_ok),
        .raddr(rd_ptr_reg[`DCF_ADDR_W-1:0]),
        .rdata(mem_rdata)
    );

    assign rd_data = rd_data_reg;
    assign rd_data_oe = rd_data_oe_reg;
    assign flags = dcf_pkg::dcf_flags_s'({full_b_reg, empty_b_reg, almost_full_b_reg,
        almost_empty_b_reg});
    assign load_mode = load_mode_reg;
endmodule

// [bench/dcf_fifo_sva.sv]
`timescale 1ns/1ps
module dcf_fifo_sva (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wr_tick,
    input wire logic rd_tick,
    input wire logic primary_write_enable_b,
    input wire logic out_enable_b,
    input wire logic [8:0] rd_data,
    input wire logic rd_data_oe,
    input wire dcf_pkg::dcf_flags_s flags,
    input wire logic load_mode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_rst; !$past(rst_b) |-> rd_data == 9'h000 && flags == 4'hA; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_oe; $rose(out_enable_b) |=> !rd_data_oe; endproperty
    a_oe: assert property (p_oe) else $error("output not floated");
    property p_faf; !flags.full_b |-> !flags.almost_full_b; endproperty
    a_faf: assert property (p_faf) else $error("full without almost full");
    property p_eae; !flags.empty_b |-> !flags.almost_empty_b; endproperty
    a_eae: assert property (p_eae) else $error("empty without almost empty");
    property p_ft; $changed(flags.full_b) |-> $past(wr_tick); endproperty
    a_ft: assert property (p_ft) else $error("full moved off write edge");
    property p_et; $changed(flags.empty_b) |-> $past(rd_tick); endproperty
    a_et: assert property (p_et) else $error("empty moved off read edge");
    property p_fc; $fell(flags.full_b) |-> !$past(primary_write_enable_b); endproperty
    a_fc: assert property (p_fc) else $error("full without a write");
    // the strap lands one edge after release, so compare only from the third edge on
    property p_ld; $past(rst_b, 2) |-> $stable(load_mode); endproperty
    a_ld: assert property (p_ld) else $error("pin role moved");
    c_full: cover property ($fell(flags.full_b));
    c_first: cover property ($rose(flags.empty_b));
    c_load: cover property (load_mode);
endmodule
bind dcf_fifo dcf_fifo_sva u_sva (.sys_clk, .rst_b, .wr_tick, .rd_tick, .primary_write_enable_b,
    .out_enable_b, .rd_data, .rd_data_oe, .flags, .load_mode);

// [bench/dcf_side_model.sv]
`timescale 1ns/1ps
module dcf_side_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wr_go,
    output logic wr_en_b,
    output logic rd_tick,
    output logic [8:0] wr_data
);
    logic [1:0] div_reg;
    // read side runs at a third of the write rate, so flags lag visibly
    assign rd_tick = div_reg == 2'h0;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= 2'h0;
            wr_data <= 9'h000;
            wr_en_b <= 1'b1;
        end else begin
            div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
            wr_en_b <= !wr_go;
            if (!wr_en_b) begin
                wr_data <= wr_data + 9'h001;
            end
        end
    end
endmodule

// [bench/dcf_fifo_tb.sv]
`timescale 1ns/1ps
module dcf_fifo_tb;
    typedef struct packed {
        logic [15:0] cnt;
        logic [13:0] n;
        logic [13:0] m;
        dcf_pkg::dcf_flags_s f;
    } dcf_row_s;
    logic sys_clk, rst_b, wr_go, wr_tick, rd_tick, primary_write_enable_b;
    logic dual_role_write_or_load_pin, read_enable_pair_b, out_enable_b, rd_data_oe, load_mode;
    logic [8:0] wr_data, rd_data;
    logic [13:0] empty_offset_n, full_offset_m;
    dcf_pkg::dcf_flags_s flags;
    int failures = 0, checks = 0, cycles = 0;
    dcf_row_s rows [6] = '{'{16'h0001, 14'h0002, 14'h0002, 4'hE}, '{16'h0003, 14'h0002, 14'h0002,
        4'hF}, '{16'h0003, 14'h0003, 14'h0002, 4'hE}, '{16'h3FFD, 14'h0002, 14'h0002, 4'hF},
        '{16'h3FFE, 14'h0002, 14'h0002, 4'hD}, '{16'h4006, 14'h0002, 14'h0002, 4'h5}};
    dcf_side_model u_side (.sys_clk, .rst_b, .wr_go, .wr_en_b(primary_write_enable_b), .rd_tick,
        .wr_data);
    dcf_fifo uut (.sys_clk, .rst_b, .wr_tick, .rd_tick, .wr_data, .primary_write_enable_b,
        .dual_role_write_or_load_pin, .read_enable_pair_b, .out_enable_b, .empty_offset_n,
        .full_offset_m, .rd_data, .rd_data_oe, .flags, .load_mode);
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flags(input dcf_pkg::dcf_flags_s got, input dcf_pkg::dcf_flags_s exp);
        chk_val({5'h00, got}, {5'h00, exp});
    endtask
    task automatic do_reset(input logic strap);
        rst_b = 1'b0;
        dual_role_write_or_load_pin = strap;
        step(12);
        chk_flags(flags, 4'hA);
        chk_val(rd_data, 9'h000);
        rst_b = 1'b1;
        step(3);
    endtask
    task automatic read_word(input logic [8:0] exp);
        int t = 0;
        read_enable_pair_b = 1'b0;
        while (rd_tick !== 1'b1 && t < 9) begin
            step(1);
            t++;
        end
        step(1);
        read_enable_pair_b = 1'b1;
        step(2);
        chk_val(rd_data, exp);
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        wr_go = 1'b0;
        wr_tick = 1'b1;
        read_enable_pair_b = 1'b1;
        out_enable_b = 1'b0;
        foreach (rows[i]) begin
            empty_offset_n = rows[i].n;
            full_offset_m = rows[i].m;
            do_reset(1'b1);
            wr_go = 1'b1;
            step(rows[i].cnt);
            wr_go = 1'b0;
            step(8);
            chk_flags(flags, rows[i].f);
        end
        // with the write side quiet the write-side flags must hold after a read
        wr_tick = 1'b0;
        read_word(9'h000);
        chk_flags(flags, 4'h5);
        wr_tick = 1'b1;
        for (int k = 1; k < 3; k++) begin
            read_word(9'(k));
        end
        step(4);
        chk_val({8'h00, flags.full_b}, 9'h001);
        out_enable_b = 1'b1;
        step(2);
        chk_val({8'h00, rd_data_oe}, 9'h000);
        out_enable_b = 1'b0;
        step(2);
        chk_val({8'h00, rd_data_oe}, 9'h001);
        do_reset(1'b1);
        dual_role_write_or_load_pin = 1'b0;
        wr_go = 1'b1;
        step(4);
        dual_role_write_or_load_pin = 1'b1;
        wr_go = 1'b0;
        step(8);
        read_word(9'h003);
        step(2);
        chk_val({8'h00, flags.empty_b}, 9'h000);
        do_reset(1'b0);
        chk_val({8'h00, load_mode}, 9'h001);
        wr_go = 1'b1;
        step(4);
        wr_go = 1'b0;
        step(8);
        chk_val({8'h00, flags.empty_b}, 9'h000);
        end_of_test();
    end
endmodule
